// [hdl/cscr_regs.sv]
// clock stop control registers and stop gating, bytes 3 to 7
`timescale 1ns/1ps
`include "cscr_defines.svh"
module cscr_regs
    import cscr_pkg::*;
#(
    parameter logic [3:0] REVISION_CODE = 4'h5, // arbitrary value
    parameter logic [3:0] VENDOR_CODE   = 4'ha  // arbitrary value
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire cscr_req_t   req,
    output      logic [7:0]  rdata,
    output      logic        rvalid,
    input  wire logic        pci_clock_halt_n,
    input  wire logic        cpu_clock_halt_n,
    input  wire logic        power_down_input,
    input  wire logic        vtt_power_good_n,
    input  wire logic        freq_select_a,
    input  wire logic        freq_select_b,
    input  wire logic        freq_select_c,
    output      cscr_run_t   run,
    output      cscr_drive_t drive,
    output      logic        test_mode,
    output      logic        test_ref_div,
    output      logic        ref_strong,
    output      logic        power_down_state
);
    // ==========================================
    // pin synchronisers
    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    logic       pci_halt;
    logic       cpu_halt;
    logic       pd_in;
    logic       pwrgd_n;
    logic [2:0] fs_pins;

    // two stages; only the second stage is read by logic
    always_ff @(posedge ref_clk) begin
        pin_s1_r <= {pci_clock_halt_n, cpu_clock_halt_n, power_down_input,
                     freq_select_c, freq_select_b, freq_select_a};
        pin_s2_r <= pin_s1_r;
    end
    assign pci_halt = ~pin_s2_r[5];
    assign cpu_halt = ~pin_s2_r[4];
    assign pd_in    = pin_s2_r[3];
    assign fs_pins  = pin_s2_r[2:0];

    // power good synchronised separately
    logic pg_s1_r;
    logic pg_s2_r;
    always_ff @(posedge ref_clk) begin
        pg_s1_r <= vtt_power_good_n;
        pg_s2_r <= pg_s1_r;
    end
    assign pwrgd_n = pg_s2_r;

    // ==========================================
    // registers
    logic [7:0] io_stop_en_r;
    logic [7:0] cpu_pci_en_r;
    logic [7:0] drive_mode_r;
    logic [7:0] test_ctl_r;
    logic [2:0] fs_latch_r;
    logic       fs_done_r;

    function automatic logic hit(input cscr_req_t q, input logic [6:0] ofs);
        hit = q.wr && (q.offset == ofs);
    endfunction : hit

    // one write strobe per register; byte 7 and unmapped offsets get none
    logic wr_io_stop;
    logic wr_cpu_pci;
    logic wr_drive_mode;
    logic wr_test_freq;
    assign wr_io_stop    = hit(req, `CSCR_OFS_IO_STOP);
    assign wr_cpu_pci    = hit(req, `CSCR_OFS_CPU_PCI);
    assign wr_drive_mode = hit(req, `CSCR_OFS_DRIVE_MODE);
    assign wr_test_freq  = hit(req, `CSCR_OFS_TEST_FREQ);

    // byte 3 per-pair stop enables
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            io_stop_en_r <= `CSCR_RST_IO_STOP;
        end else if (wr_io_stop) begin
            io_stop_en_r <= req.wdata;
        end
    end

    // byte 4; reserved bits 7 and 5 kept at 0
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpu_pci_en_r <= `CSCR_RST_CPU_PCI;
        end else if (wr_cpu_pci) begin
            cpu_pci_en_r <= req.wdata & `CSCR_B4_WR_MASK;
        end
    end

    // byte 5 drive modes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            drive_mode_r <= `CSCR_RST_DRIVE_MODE;
        end else if (wr_drive_mode) begin
            drive_mode_r <= req.wdata;
        end
    end

    // byte 6 writable bits; fs bits and reserved bit 5 not writable
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            test_ctl_r <= `CSCR_RST_TEST;
        end else if (wr_test_freq) begin
            test_ctl_r <= req.wdata & `CSCR_B6_WR_MASK;
        end
    end

    // freq select captured once, when power good first seen low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fs_latch_r <= 3'h0;
            fs_done_r  <= 1'b0;
        end else if (!fs_done_r && !pwrgd_n) begin
            fs_latch_r <= fs_pins;
            fs_done_r  <= 1'b1;
        end
    end

    // ==========================================
    // read port; byte 7 constant, writes ignored
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            case (req.offset)
                `CSCR_OFS_IO_STOP:    rdata <= io_stop_en_r;
                `CSCR_OFS_CPU_PCI:    rdata <= cpu_pci_en_r;
                `CSCR_OFS_DRIVE_MODE: rdata <= drive_mode_r;
                `CSCR_OFS_TEST_FREQ:  rdata <= {test_ctl_r[7:3], fs_latch_r};
                `CSCR_OFS_ID:         rdata <= {REVISION_CODE, VENDOR_CODE};
                default:              rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================
    // stop gating
    // pair counts; must match the run and drive field widths
    localparam int IO_PAIRS  = 8;
    localparam int CPU_PAIRS = 3;
    logic       sw_halt;
    logic       pci_stop;
    logic       pd_active;
    logic       cpu_halt_done;
    logic [2:0] cpu_halt_cnt_r;
    logic       cpu_halted_r;

    // power down follows the pin only after power good was seen
    assign pd_active = fs_done_r & pd_in;
    assign sw_halt   = ~test_ctl_r[`CSCR_B6_SW_RUN];
    // pin and software stop merged for io pairs 7 to 1 and the pci clocks
    assign pci_stop  = pci_halt | sw_halt;

    // cpu halt waits the least delay after sync before parking; the count
    // stops at its end so it cannot wrap during a long halt
    assign cpu_halt_done = (cpu_halt_cnt_r == 3'(`CSCR_CPU_HALT_DLY));

    // delay counter, cleared whenever the halt pin is released
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpu_halt_cnt_r <= 3'h0;
        end else if (!cpu_halt) begin
            cpu_halt_cnt_r <= 3'h0;
        end else if (!cpu_halt_done) begin
            cpu_halt_cnt_r <= cpu_halt_cnt_r + 3'h1;
        end
    end

    // parked flag; released at once with the pin so resume is prompt
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpu_halted_r <= 1'b0;
        end else if (!cpu_halt) begin
            cpu_halted_r <= 1'b0;
        end else if (cpu_halt_done) begin
            cpu_halted_r <= 1'b1;
        end
    end

    // ==========================================
    // next values of the run enables
    logic [IO_PAIRS-1:0]  io_run_nxt;
    logic [1:0]           free_pci_run_nxt;
    logic [CPU_PAIRS-1:0] cpu_run_nxt;
    logic                 pci_run_nxt;

    // io pair 0 follows the pin alone; the software stop never reaches it
    assign io_run_nxt[0] = ~(io_stop_en_r[0] & pci_halt);

    // io pairs 7 to 1 obey the pin and the software stop alike
    for (genvar g = 1; g < IO_PAIRS; g++) begin : g_io_run
        assign io_run_nxt[g] = ~(io_stop_en_r[g] & pci_stop);
    end

    // free pci clocks stop only when their enable bit is set
    for (genvar g = 0; g < 2; g++) begin : g_free_pci_run
        assign free_pci_run_nxt[g] =
            ~(cpu_pci_en_r[`CSCR_B4_FREE_PCI_CLOCK_0 + g] & pci_stop);
    end

    // cpu pairs ignore the pci stop; they park only after the halt delay
    for (genvar g = 0; g < CPU_PAIRS; g++) begin : g_cpu_run
        assign cpu_run_nxt[g] =
            ~(cpu_pci_en_r[`CSCR_B4_CPU_STOP + g] & cpu_halted_r);
    end

    // plain pci clocks have no enable bit and always obey the stop
    assign pci_run_nxt = ~pci_stop;

    // ==========================================
    // next values of the drive enables
    logic                 io_pd_float;
    logic [IO_PAIRS-1:0]  io_drive_nxt;
    logic [CPU_PAIRS-1:0] cpu_drive_nxt;
    logic                 dot_drive_nxt;

    // every io pair floats in power down when the mode bit asks for it
    assign io_pd_float = pd_active & drive_mode_r[`CSCR_B5_IO_PD_HZ];

    // a pair floats on a stop only once it has really stopped, so a pair
    // left free running keeps its drive whatever the stop mode says
    for (genvar g = 0; g < IO_PAIRS; g++) begin : g_io_drive
        assign io_drive_nxt[g] = ~(io_pd_float
            | (~run.io_run[g] & drive_mode_r[`CSCR_B5_IO_STOP_HZ]));
    end

    // cpu pairs have their own stop and power down mode bits
    for (genvar g = 0; g < CPU_PAIRS; g++) begin : g_cpu_drive
        logic pd_float;
        logic stop_float;
        assign pd_float   = pd_active & drive_mode_r[`CSCR_B5_CPU_PD_HZ + g];
        assign stop_float = cpu_pci_en_r[`CSCR_B4_CPU_STOP + g] & cpu_halted_r
                            & drive_mode_r[`CSCR_B5_CPU_STOP_HZ + g];
        assign cpu_drive_nxt[g] = ~(pd_float | stop_float);
    end

    // the dot pair is touched by power down only
    assign dot_drive_nxt = ~(pd_active & cpu_pci_en_r[`CSCR_B4_DOT_PD]);

    // ==========================================
    // output registers, one per concern, so stops land on one edge
    // run enables; every clock runs out of reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            run <= '1;
        end else begin
            run.io_run       <= io_run_nxt;
            run.free_pci_run <= free_pci_run_nxt;
            run.cpu_run      <= cpu_run_nxt;
            run.pci_run      <= pci_run_nxt;
        end
    end

    // drive enables; every differential output driven out of reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            drive <= '1;
        end else begin
            drive.io_drive  <= io_drive_nxt;
            drive.cpu_drive <= cpu_drive_nxt;
            drive.dot_drive <= dot_drive_nxt;
        end
    end

    // test clock mode controls
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            test_mode    <= 1'b0;
            test_ref_div <= 1'b0;
        end else begin
            test_mode    <= test_ctl_r[`CSCR_B6_TEST_EN];
            test_ref_div <= test_ctl_r[`CSCR_B6_REFN_SEL];
        end
    end

    // reference output strength; strong out of reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ref_strong <= 1'b1;
        end else begin
            ref_strong <= test_ctl_r[`CSCR_B6_REF_STRONG];
        end
    end

    // power down state seen by the rest of the chip
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_down_state <= 1'b0;
        end else begin
            power_down_state <= pd_active;
        end
    end
endmodule : cscr_regs

// [hdl/cscr_defines.svh]
// constants for the clock stop control register bank
`ifndef CSCR_DEFINES_SVH
`define CSCR_DEFINES_SVH
// ==========================================
// offsets
`define CSCR_OFS_IO_STOP    7'h03
`define CSCR_OFS_CPU_PCI    7'h04
`define CSCR_OFS_DRIVE_MODE 7'h05
`define CSCR_OFS_TEST_FREQ  7'h06
`define CSCR_OFS_ID         7'h07
// ==========================================
// reset values
`define CSCR_RST_IO_STOP    8'h00
`define CSCR_RST_CPU_PCI    8'h07
`define CSCR_RST_DRIVE_MODE 8'h00
`define CSCR_RST_TEST       8'h18
// ==========================================
// field positions
`define CSCR_CMD_BYTE_MODE  7
`define CSCR_B4_DOT_PD      6
`define CSCR_B4_FREE_PCI_CLOCK_1       4
`define CSCR_B4_FREE_PCI_CLOCK_0       3
`define CSCR_B5_IO_STOP_HZ  7
`define CSCR_B5_IO_PD_HZ    3
`define CSCR_B4_CPU_STOP    0
`define CSCR_B4_WR_MASK     8'h5f
`define CSCR_B5_CPU_STOP_HZ 4
`define CSCR_B5_CPU_PD_HZ   0
`define CSCR_B6_REFN_SEL    7
`define CSCR_B6_TEST_EN     6
`define CSCR_B6_REF_STRONG  4
`define CSCR_B6_SW_RUN      3
`define CSCR_B6_WR_MASK     8'hd8
// ==========================================
// timing: least halt delay in ref_clk periods
`define CSCR_CPU_HALT_DLY   2
`endif

// [hdl/cscr_pkg.sv]
// types of the clock stop control register bank
package cscr_pkg;
    // gated run enables for the clock outputs
    typedef struct packed {
        logic [7:0] io_run;
        logic [1:0] free_pci_run;
        logic [2:0] cpu_run;
        logic       pci_run;
    } cscr_run_t;
    // drive enables (0 = hi-z) per differential output
    typedef struct packed {
        logic [7:0] io_drive;
        logic [2:0] cpu_drive;
        logic       dot_drive;
    } cscr_drive_t;
    // register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] offset;
        logic [7:0] wdata;
    } cscr_req_t;
endpackage : cscr_pkg

// [test/cscr_host.sv]
// host-side model issuing single-byte register accesses
`timescale 1ns/1ps
module cscr_host
    import cscr_pkg::*;
(
    input  wire logic       ref_clk,
    output      cscr_req_t  req,
    input  wire logic [7:0] rdata
);
    initial req = '0;
    // byte mode only, so every request names exactly one offset
    task automatic wr(input logic [6:0] o, input logic [7:0] d);
        @(posedge ref_clk) req <= '{1'b1, 1'b0, o, d};
        @(posedge ref_clk) req <= '{1'b0, 1'b0, ~o, ~d}; // released fields show junk
    endtask : wr
    // read data is registered, so it is taken one edge after the request
    task automatic rd(input logic [6:0] o, output logic [7:0] d);
        @(posedge ref_clk) req <= '{1'b0, 1'b1, o, 8'h00};
        @(posedge ref_clk) req <= '{1'b0, 1'b0, ~o, 8'hff};
        #1 d = rdata;
    endtask : rd
endmodule : cscr_host

// [test/cscr_regs_chk.sv]
// concurrent checks on the ports of the clock stop register bank
`timescale 1ns/1ps
module cscr_regs_chk
    import cscr_pkg::*;
#(
    parameter logic [3:0] REVISION_CODE = 4'h5, // arbitrary value
    parameter logic [3:0] VENDOR_CODE   = 4'ha  // arbitrary value
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire cscr_req_t   req,
    input wire logic [7:0]  rdata,
    input wire logic        rvalid,
    input wire logic        pci_clock_halt_n,
    input wire logic        cpu_clock_halt_n,
    input wire logic        power_down_input,
    input wire logic        vtt_power_good_n,
    input wire logic        freq_select_a,
    input wire logic        freq_select_b,
    input wire logic        freq_select_c,
    input wire cscr_run_t   run,
    input wire cscr_drive_t drive,
    input wire logic        test_mode,
    input wire logic        test_ref_div,
    input wire logic        ref_strong,
    input wire logic        power_down_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==========
    // read path, stop gating and reset levels
    sequence sw_wr(b); req.wr && req.offset == 7'h06 && req.wdata[3] == b; endsequence
    a_read_valid: assert property (req.rd |=> rvalid) else $error("no rvalid");
    a_valid_cause: assert property (rvalid |-> $past(req.rd)) else $error("stray rvalid");
    a_id_value: assert property (req.rd && req.offset == 7'h07 |=>
        rdata == {REVISION_CODE, VENDOR_CODE}) else $error("bad id byte");
    a_unmapped_zero: assert property (req.rd && (req.offset < 7'h03 || req.offset > 7'h07)
        |=> rdata == 8'h00) else $error("unmapped read not zero");
    a_sw_halt: assert property (sw_wr(1'b0) |=> ##1 !run.pci_run) else $error("no halt");
    a_sw_resume: assert property (pci_clock_halt_n [*5] ##0 sw_wr(1'b1) |=> ##1
        run.pci_run) else $error("no resume");
    a_hw_halt: assert property ((!pci_clock_halt_n) [*5] |-> !run.pci_run) else $error("pin halt");
    a_reset_levels: assert property ($fell(rst) |-> &run && &drive && ref_strong &&
        !test_mode && !power_down_state) else $error("bad reset levels");
endmodule : cscr_regs_chk
bind cscr_regs cscr_regs_chk #(.REVISION_CODE(REVISION_CODE), .VENDOR_CODE(VENDOR_CODE))
    cscr_regs_chk_i (.ref_clk, .rst, .req, .rdata, .rvalid, .pci_clock_halt_n,
    .cpu_clock_halt_n, .power_down_input, .vtt_power_good_n, .freq_select_a, .freq_select_b,
    .freq_select_c, .run, .drive, .test_mode, .test_ref_div, .ref_strong, .power_down_state);

// [test/tb_cscr_regs.sv]
// self-checking bench for the clock stop register bank
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_cscr_regs
    import cscr_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        pci_clock_halt_n = 1'b1;
    logic        cpu_clock_halt_n = 1'b1;
    logic        power_down_input = 1'b0;
    logic        vtt_power_good_n = 1'b1;
    logic [2:0]  fs = 3'b101; // c, b, a
    cscr_req_t   req;
    logic [7:0]  rdata;
    logic [7:0]  d;
    cscr_run_t   run;
    cscr_drive_t drive;
    logic        rvalid, test_mode, test_ref_div, ref_strong, power_down_state;
    int          num_errors = 0;
    int          samples_checked = 0;
    logic [7:0]  rst_exp [7] = '{8'h00, 8'h00, 8'h07, 8'h00, 8'h1d, 8'h5a, 8'h00};
    logic [7:0]  wr_exp [5] = '{8'hff, 8'h5f, 8'hff, 8'hdd, 8'h5a};
    always #2.5 ref_clk = ~ref_clk;
    cscr_host cscr_host_i (.ref_clk, .req, .rdata);
    cscr_regs cscr_regs_i (.ref_clk, .rst, .req, .rdata, .rvalid, .pci_clock_halt_n,
        .cpu_clock_halt_n, .power_down_input, .vtt_power_good_n, .freq_select_a(fs[0]),
        .freq_select_b(fs[1]), .freq_select_c(fs[2]), .run, .drive, .test_mode,
        .test_ref_div, .ref_strong, .power_down_state);
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle
    task automatic end_of_test();
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        end_of_test();
    end
    // ==========
    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        vtt_power_good_n <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            cscr_host_i.rd(7'(i + 2), d);
            `CHK(d, rst_exp[i])
        end
        for (int i = 0; i < 5; i++) begin
            cscr_host_i.wr(7'(i + 3), 8'hff);
            cscr_host_i.rd(7'(i + 3), d);
            `CHK(d, wr_exp[i])
        end
        settle(2);
        `CHK({test_mode, test_ref_div, ref_strong}, 3'b111)
        cscr_host_i.wr(7'h06, 8'h00);
        settle(3);
        `CHK({test_mode, ref_strong}, 2'b00)
        // pair 0 ignores the software halt, so it alone keeps running
        `CHK({run.io_run, run.free_pci_run, run.pci_run, drive.io_drive}, 19'h00801)
        cscr_host_i.wr(7'h06, 8'h18);
        settle(3);
        `CHK({run.io_run, run.free_pci_run, run.pci_run}, 11'h7ff)
        @(posedge ref_clk) pci_clock_halt_n <= 1'b0;
        settle(5);
        `CHK({run.io_run, drive.io_drive}, 16'h0000)
        @(posedge ref_clk) pci_clock_halt_n <= 1'b1;
        settle(5);
        `CHK({run.io_run, run.free_pci_run, run.pci_run}, 11'h7ff)
        cscr_host_i.wr(7'h04, 8'h5d);
        cpu_clock_halt_n <= 1'b0;
        settle(8);
        `CHK({run.cpu_run, drive.cpu_drive}, 6'b010010)
        @(posedge ref_clk) cpu_clock_halt_n <= 1'b1;
        settle(8);
        `CHK(run.cpu_run, 3'b111)
        @(posedge ref_clk) power_down_input <= 1'b1;
        settle(8);
        `CHK({drive.io_drive, drive.cpu_drive, drive.dot_drive, power_down_state}, 13'h1)
        cscr_host_i.wr(7'h05, 8'h00);
        cscr_host_i.wr(7'h04, 8'h07);
        settle(3);
        `CHK({drive.io_drive, drive.cpu_drive, drive.dot_drive}, 12'hfff)
        end_of_test();
    end
endmodule : tb_cscr_regs
